/* File: core/bbs_pkg.sv */
// Contract
// [R1] Safety switch inputs watched always; active is fault
// [R2] Valve and vent feedback must follow outputs
// [R3] Flow required only while pump runs
// [R4] Igniter current expected 18 s after on
// [R5] Flame expected 5 s after gas on
// [R6] Central: idle, precirc, heat, postcirc, fault states
// [R7] Idle: standby lit, outputs off, pump if continuous
// [R8] Precirc: running lit, vent/valve on, cold purge
// [R9] Heat: stage one first, others in order
// [R10] Soft fault: outputs off, pump postcirc, alarm, service
// [R11] Soft fault exits: hour, link, select, limit cleared
// [R12] Hard fault: service flashes, exit on select only
// [R13] Stage runs purge, ignite, flame, heat, postpurge
// [R14] Three tries with inter-purge, then stage error
// [R15] Prepurge 10 s, 34 s cold, skipped without blower
// [R16] Igniter 18-20 s, needs current, else trial fails
// [R17] Gas relay confirmed 1.5 s after valve opens; code checks at RELAY_CHECK_S, 2 s rounded up
// [R18] Flame sensed within 5 s, else trial fails
// [R19] Stage heats until call drops, faults to error
// [R20] Inter-purge: gas, igniter off, blower 15 s
// [R21] Postpurge: blower 25 s, or idle at once
// [R22] Stage error reports code until central clears
// [R23] Durations counted in seconds from divided tick
package bbs_pkg;
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned TICK_CYCLES = CLK_HZ;
	// Register offsets
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] STATUS_OFF = 8'h04;
	localparam logic [7:0] STAGE_ERR_OFF = 8'h08;
	localparam logic [7:0] LOG_OFF = 8'h0C;
	// Control fields
	localparam int CTRL_TRIES_BIT = 0;
	localparam int CTRL_POST_LSB = 1;
	localparam int CTRL_VENT_BIT = 3;
	localparam int CTRL_ISO_BIT = 4;
	localparam int CTRL_ACT_LSB = 8;
	localparam int CTRL_BLW_LSB = 12;
	localparam int CTRL_DEM_LSB = 16;
	localparam logic [31:0] CTRL_RESET = 32'h0000_1119;
	localparam logic [1:0] POST_CONT = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	// Stage durations in seconds (relay check given in ms)
	localparam logic [5:0] PREPURGE_S = 6'd10;
	localparam logic [5:0] COLD_PURGE_S = 6'd34;
	localparam logic [5:0] IGN_MIN_S = 6'd18;
	localparam logic [5:0] IGN_MAX_S = 6'd20;
	localparam int RELAY_CHECK_MS = 1500;
	localparam logic [5:0] RELAY_CHECK_S = 6'((RELAY_CHECK_MS + 999) / 1000);
	localparam logic [5:0] FLAME_WAIT_S = 6'd5;
	localparam logic [5:0] INTERPURGE_S = 6'd15;
	localparam logic [5:0] POSTPURGE_S = 6'd25;
	localparam logic [5:0] IGN_CUR_EXPECT_S = 6'd18;
	localparam logic [5:0] FLAME_EXPECT_S = 6'd5;
	localparam logic [1:0] TRIES_MAX = 2'd3;
	// Central durations in seconds
	localparam logic [11:0] POST_45_S = 12'd45;
	localparam logic [11:0] POST_90_S = 12'd90;
	localparam logic [11:0] POST_180_S = 12'd180;
	localparam logic [11:0] SOFT_RETRY_S = 12'd3600;
	localparam logic [11:0] FB_SETTLE_S = 12'd2;
	// Central fault codes
	localparam logic [3:0] FLT_NONE = 4'h0;
	localparam logic [3:0] FLT_OVERTEMP = 4'h1;
	localparam logic [3:0] FLT_LOW_WATER = 4'h2;
	localparam logic [3:0] FLT_FLUE = 4'h3;
	localparam logic [3:0] FLT_GAS_LOW = 4'h4;
	localparam logic [3:0] FLT_HIGH_LIMIT = 4'h5;
	localparam logic [3:0] FLT_GAS_HIGH = 4'h6;
	localparam logic [3:0] FLT_ISO_FB = 4'h7;
	localparam logic [3:0] FLT_VENT_FB = 4'h8;
	localparam logic [3:0] FLT_FLOW = 4'h9;
	localparam logic [3:0] FLT_COMM = 4'hA;
	localparam logic [3:0] FLT_STAGE = 4'hB;
	// Stage error codes
	localparam logic [1:0] SERR_NONE = 2'h0;
	localparam logic [1:0] SERR_IGNITION = 2'h1;
	localparam logic [1:0] SERR_IGN_CUR = 2'h2;
	localparam logic [1:0] SERR_FLAME = 2'h3;
	typedef enum logic [2:0] {
		CC_IDLE, CC_PRECIRC, CC_HEAT, CC_POSTCIRC, CC_SOFT, CC_HARD
	} bbs_cc_state_t;
	typedef enum logic [3:0] {
		ST_IDLE, ST_PREPURGE, ST_IGNITE, ST_GAS_PROVE, ST_FLAME_WAIT,
		ST_HEATING, ST_INTERPURGE, ST_POSTPURGE, ST_ERROR
	} bbs_st_state_t;
endpackage

/* File: core/bbs_sequencer.sv */
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module bbs_sequencer #(
	parameter int unsigned TICK_CYCLES = bbs_pkg::TICK_CYCLES,
	parameter int STAGES = 4
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Register bus
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Safety and feedback switches, high when true
	input wire logic overtemp_cutoff_switch,
	input wire logic low_water_cutoff,
	input wire logic flue_blocked,
	input wire logic gas_pressure_low,
	input wire logic outlet_high_limit,
	input wire logic gas_pressure_high,
	input wire logic isolation_valve_feedback,
	input wire logic vent_feedback,
	input wire logic water_flow,
	input wire logic thermostat_closed,
	input wire logic comm_lost,
	input wire logic outlet_below_reset,
	// User panel
	input wire logic user_select_key,
	input wire logic error_screen_shown,
	// Stage sensing
	input wire logic [STAGES-1:0] igniter_current_ok,
	input wire logic [STAGES-1:0] flame_sensed,
	input wire logic [STAGES-1:0] gas_relay_feedback,
	// Central outputs
	output logic pump_on,
	output logic vent_output,
	output logic isolation_valve_output,
	output logic alarm_output,
	output logic led_standby,
	output logic led_running,
	output logic led_service,
	output logic fault_log_strobe,
	output logic [3:0] fault_log_code,
	// Stage outputs
	output logic [STAGES-1:0] blower_on,
	output logic [STAGES-1:0] igniter_on,
	output logic [STAGES-1:0] gas_valve_on
);
	import bbs_pkg::*;

	localparam int IN_W = 14 + 3 * STAGES;
	localparam int TW = $clog2(TICK_CYCLES + 1);

	// Pin synchronisers
	logic [IN_W-1:0] sync1;
	logic [IN_W-1:0] sync2;
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= {overtemp_cutoff_switch, low_water_cutoff, flue_blocked,
				gas_pressure_low, outlet_high_limit, gas_pressure_high,
				isolation_valve_feedback, vent_feedback, water_flow,
				thermostat_closed, comm_lost, outlet_below_reset,
				user_select_key, error_screen_shown, igniter_current_ok,
				flame_sensed, gas_relay_feedback};
			sync2 <= sync1;
		end
	end
	logic s_ot, s_lw, s_flue, s_glow, s_hl, s_ghigh, s_isofb, s_ventfb;
	logic s_flow, s_tstat, s_comm, s_below, s_sel, s_screen;
	logic [STAGES-1:0] s_icur, s_flame, s_relay;
	assign {s_ot, s_lw, s_flue, s_glow, s_hl, s_ghigh, s_isofb, s_ventfb,
		s_flow, s_tstat, s_comm, s_below, s_sel, s_screen, s_icur,
		s_flame, s_relay} = sync2;

	// One-second tick
	logic [TW-1:0] tick_cnt, next_tick_cnt;
	logic tick;
	always_comb begin
		tick = (tick_cnt == TW'(TICK_CYCLES - 1)); // [R23]
		next_tick_cnt = tick ? '0 : tick_cnt + 1'b1;
	end
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset)
			tick_cnt <= '0;
		else
			tick_cnt <= next_tick_cnt;
	end

	// Register bus
	logic aw_held, next_aw_held, w_held, next_w_held;
	logic [7:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data, ctrl, next_ctrl;
	logic [31:0] rd_mux, next_rdata;
	logic [3:0] w_strb, next_w_strb;
	logic next_bvalid, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] status_word, stage_err_word;
	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;
	assign s_axi_arready = !s_axi_rvalid;
	always_comb begin
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held = w_held;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = s_axi_bvalid && !s_axi_bready;
		next_bresp = s_axi_bresp;
		next_ctrl = ctrl;
		next_rvalid = s_axi_rvalid && !s_axi_rready;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_awvalid && !aw_held) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_held) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (aw_held && w_held && !s_axi_bvalid) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = RESP_OKAY;
			case (aw_addr)
				CTRL_OFF: begin
					for (int b = 0; b < 4; b++)
						if (w_strb[b])
							next_ctrl[b*8 +: 8] = w_data[b*8 +: 8];
				end
				STATUS_OFF, STAGE_ERR_OFF, LOG_OFF: ;
				default: next_bresp = RESP_DECERR;
			endcase
		end
		case (s_axi_araddr)
			CTRL_OFF: rd_mux = ctrl;
			STATUS_OFF: rd_mux = status_word;
			STAGE_ERR_OFF: rd_mux = stage_err_word;
			LOG_OFF: rd_mux = {28'h0000000, fault_log_code};
			default: rd_mux = 32'h0000_0000;
		endcase
		if (s_axi_arvalid && !s_axi_rvalid) begin
			next_rvalid = 1'b1;
			next_rdata = rd_mux;
			next_rresp = (s_axi_araddr == CTRL_OFF ||
				s_axi_araddr == STATUS_OFF ||
				s_axi_araddr == STAGE_ERR_OFF ||
				s_axi_araddr == LOG_OFF) ? RESP_OKAY : RESP_DECERR;
		end
	end
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			ctrl <= CTRL_RESET;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			aw_held <= next_aw_held;
			aw_addr <= next_aw_addr;
			w_held <= next_w_held;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			ctrl <= next_ctrl;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end

	// Configuration fields
	logic three_tries, vent_en, iso_en, post_cont;
	logic [1:0] post_sel;
	logic [3:0] stage_active, stage_blower;
	logic [2:0] demand;
	logic [11:0] post_time;
	always_comb begin
		three_tries = ctrl[CTRL_TRIES_BIT];
		post_sel = ctrl[CTRL_POST_LSB +: 2];
		vent_en = ctrl[CTRL_VENT_BIT];
		iso_en = ctrl[CTRL_ISO_BIT];
		stage_active = ctrl[CTRL_ACT_LSB +: 4];
		stage_blower = ctrl[CTRL_BLW_LSB +: 4];
		demand = ctrl[CTRL_DEM_LSB +: 3];
		post_cont = (post_sel == POST_CONT);
		case (post_sel)
			2'h1: post_time = POST_90_S;
			2'h2: post_time = POST_180_S;
			default: post_time = POST_45_S;
		endcase
	end

	// Stage command and status lines
	logic [STAGES-1:0] st_call, st_cold, st_heating, st_purge_done;
	logic [STAGES-1:0] st_error;
	logic [4*STAGES-1:0] st_code;
	logic [2*STAGES-1:0] st_err_code;
	logic st_shutdown, st_clear;

	for (genvar i = 0; i < STAGES; i++) begin : g_stage
		bbs_st_state_t state, next_state;
		logic [5:0] cnt, next_cnt, ign_secs, next_ign_secs;
		logic [5:0] gas_secs, next_gas_secs, purge_len;
		logic [1:0] tries, next_tries, err, next_err, mon_err, ign_d, gas_d;
		logic cold, next_cold, fail, has_blw;
		logic next_blw, next_ign, next_gas;
		always_comb begin
			has_blw = stage_blower[i];
			next_state = state;
			next_tries = tries;
			next_cold = cold;
			next_err = err;
			fail = 1'b0;
			purge_len = cold ? COLD_PURGE_S : PREPURGE_S; // [R15]
			mon_err = SERR_NONE;
			if (!ign_d[1] && s_icur[i]) // [R4]
				mon_err = SERR_IGN_CUR;
			else if (igniter_on[i] && ign_secs >= IGN_CUR_EXPECT_S &&
				!s_icur[i] && state != ST_IGNITE) // [R4]
				mon_err = SERR_IGN_CUR;
			else if (!gas_d[1] && s_flame[i]) // [R5]
				mon_err = SERR_FLAME;
			else if (gas_valve_on[i] && gas_secs >= FLAME_EXPECT_S &&
				!s_flame[i] && state != ST_FLAME_WAIT) // [R5]
				mon_err = SERR_FLAME;
			case (state)
				ST_IDLE: begin
					if (st_cold[i] || st_call[i]) begin // [R13]
						next_cold = st_cold[i];
						next_tries = 2'd0;
						next_state = ST_PREPURGE;
					end
				end
				ST_PREPURGE: begin
					if (!has_blw || cnt >= purge_len) // [R15]
						next_state = cold ? ST_IDLE : ST_IGNITE;
					else if (!cold && !st_call[i])
						next_state = ST_POSTPURGE;
				end
				ST_IGNITE: begin
					if (cnt >= IGN_MIN_S && s_icur[i]) // [R16]
						next_state = ST_GAS_PROVE;
					else if (cnt >= IGN_MAX_S) // [R16]
						fail = 1'b1;
				end
				ST_GAS_PROVE: begin
					if (cnt >= RELAY_CHECK_S) begin // [R17]
						if (s_relay[i])
							next_state = ST_FLAME_WAIT;
						else
							fail = 1'b1;
					end
				end
				ST_FLAME_WAIT: begin
					if (s_flame[i]) // [R18]
						next_state = ST_HEATING;
					else if (cnt >= FLAME_WAIT_S) // [R18]
						fail = 1'b1;
				end
				ST_HEATING: begin
					if (!st_call[i]) // [R19]
						next_state = ST_POSTPURGE;
				end
				ST_INTERPURGE: begin
					if (cnt >= INTERPURGE_S) // [R20]
						next_state = ST_IGNITE;
				end
				ST_POSTPURGE: begin
					if (!has_blw || cnt >= POSTPURGE_S) // [R21]
						next_state = ST_IDLE;
				end
				ST_ERROR: begin
					if (st_clear) begin // [R22]
						next_state = ST_IDLE;
						next_err = SERR_NONE;
					end
				end
				default: next_state = ST_IDLE;
			endcase
			if (fail) begin
				if (three_tries && tries + 2'd1 < TRIES_MAX) begin // [R14]
					next_tries = tries + 2'd1;
					next_state = ST_INTERPURGE;
				end else begin
					next_err = SERR_IGNITION; // [R14]
					next_state = ST_ERROR;
				end
			end
			if (state != ST_ERROR && mon_err != SERR_NONE) begin // [R19]
				next_err = mon_err;
				next_state = ST_ERROR;
			end else if (state != ST_ERROR && st_shutdown)
				next_state = ST_IDLE;
			if (next_state != state)
				next_cnt = 6'd0; // [R23]
			else
				next_cnt = (tick && cnt != 6'h3F) ? cnt + 6'd1 : cnt;
			next_blw = has_blw && next_state != ST_IDLE &&
				next_state != ST_ERROR; // [R20] [R21]
			next_ign = next_state == ST_IGNITE ||
				next_state == ST_GAS_PROVE ||
				next_state == ST_FLAME_WAIT; // [R18]
			next_gas = next_state == ST_GAS_PROVE ||
				next_state == ST_FLAME_WAIT ||
				next_state == ST_HEATING; // [R17]
			next_ign_secs = !igniter_on[i] ? 6'd0 :
				(tick && ign_secs != 6'h3F) ? ign_secs + 6'd1 : ign_secs;
			next_gas_secs = !gas_valve_on[i] ? 6'd0 :
				(tick && gas_secs != 6'h3F) ? gas_secs + 6'd1 : gas_secs;
		end
		always_ff @(posedge core_clk or posedge reset) begin
			if (reset) begin
				state <= ST_IDLE;
				cnt <= 6'd0;
				ign_secs <= 6'd0;
				gas_secs <= 6'd0;
				tries <= 2'd0;
				err <= SERR_NONE;
				cold <= 1'b0;
				ign_d <= 2'd0;
				gas_d <= 2'd0;
				blower_on[i] <= 1'b0;
				igniter_on[i] <= 1'b0;
				gas_valve_on[i] <= 1'b0;
			end else begin
				state <= next_state;
				cnt <= next_cnt;
				ign_secs <= next_ign_secs;
				gas_secs <= next_gas_secs;
				tries <= next_tries;
				err <= next_err;
				cold <= next_cold;
				ign_d <= {ign_d[0], igniter_on[i]};
				gas_d <= {gas_d[0], gas_valve_on[i]};
				blower_on[i] <= next_blw;
				igniter_on[i] <= next_ign;
				gas_valve_on[i] <= next_gas;
			end
		end
		assign st_heating[i] = (state == ST_HEATING);
		assign st_error[i] = (state == ST_ERROR);
		assign st_purge_done[i] = cold && state == ST_PREPURGE &&
			next_state == ST_IDLE;
		assign st_code[i*4 +: 4] = state;
		assign st_err_code[i*2 +: 2] = err; // [R22]
	end

	// Central controller
	bbs_cc_state_t cc_state, next_cc_state;
	logic [11:0] sec, next_sec;
	logic [3:0] fault_code, next_fault_code, fault_src, next_log_code;
	logic [3:0] cold_done, next_cold_done;
	logic flash, next_flash, sel_prev, sel_press, exit_fault;
	logic heat_req, hard_cond, soft_cond, in_fault, fb_window;
	logic next_pump, next_vent, next_iso, next_alarm;
	logic next_standby, next_running, next_service;
	always_comb begin
		heat_req = s_tstat && demand != 3'd0;
		in_fault = cc_state == CC_SOFT || cc_state == CC_HARD;
		fb_window = sec >= FB_SETTLE_S;
		sel_press = s_sel && !sel_prev && s_screen;
		fault_src = FLT_NONE;
		if (s_ot) // [R1]
			fault_src = FLT_OVERTEMP;
		else if (s_lw)
			fault_src = FLT_LOW_WATER;
		else if (s_flue)
			fault_src = FLT_FLUE;
		else if (s_ghigh)
			fault_src = FLT_GAS_HIGH;
		else if (|st_error)
			fault_src = FLT_STAGE;
		else if (fb_window && s_isofb != isolation_valve_output) // [R2]
			fault_src = FLT_ISO_FB;
		else if (fb_window && s_ventfb != vent_output) // [R2]
			fault_src = FLT_VENT_FB;
		else if (s_glow)
			fault_src = FLT_GAS_LOW;
		else if (s_hl)
			fault_src = FLT_HIGH_LIMIT;
		else if (fb_window && pump_on && !s_flow) // [R3]
			fault_src = FLT_FLOW;
		else if (s_comm)
			fault_src = FLT_COMM;
		soft_cond = fault_src >= FLT_GAS_LOW && fault_src != FLT_STAGE &&
			fault_src != FLT_ISO_FB && fault_src != FLT_VENT_FB;
		hard_cond = fault_src != FLT_NONE && !soft_cond;
		exit_fault = 1'b0;
		next_cc_state = cc_state;
		next_fault_code = fault_code;
		next_cold_done = cold_done | st_purge_done;
		case (cc_state)
			CC_IDLE: begin
				next_cold_done = 4'h0;
				if (heat_req) // [R7]
					next_cc_state = CC_PRECIRC;
			end
			CC_PRECIRC: begin
				if (!heat_req)
					next_cc_state = CC_POSTCIRC;
				else if (&(cold_done | ~stage_active)) // [R8]
					next_cc_state = CC_HEAT;
			end
			CC_HEAT: begin
				if (!heat_req) // [R9]
					next_cc_state = CC_POSTCIRC;
			end
			CC_POSTCIRC: begin
				if (sec >= post_time) // [R6]
					next_cc_state = CC_IDLE;
			end
			CC_SOFT: begin
				if (hard_cond) begin
					next_cc_state = CC_HARD;
					next_fault_code = fault_src;
				end else if (sec >= SOFT_RETRY_S || sel_press ||
					(fault_code == FLT_COMM && !s_comm) ||
					(fault_code == FLT_HIGH_LIMIT && s_below)) // [R11]
					exit_fault = 1'b1;
			end
			CC_HARD: begin
				if (sel_press) // [R12]
					exit_fault = 1'b1;
			end
			default: next_cc_state = CC_IDLE;
		endcase
		if (!in_fault && fault_src != FLT_NONE) begin // [R6]
			next_cc_state = hard_cond ? CC_HARD : CC_SOFT;
			next_fault_code = fault_src;
		end
		next_log_code = fault_log_code;
		if (exit_fault) begin
			next_cc_state = CC_IDLE;
			next_fault_code = FLT_NONE;
			next_log_code = fault_code; // [R11] [R12]
		end
		if (next_cc_state != cc_state)
			next_sec = 12'd0; // [R23]
		else
			next_sec = (tick && sec != 12'hFFF) ? sec + 12'd1 : sec;
		next_flash = tick ? !flash : flash;
		next_standby = next_cc_state == CC_IDLE; // [R7]
		next_running = next_cc_state == CC_PRECIRC ||
			next_cc_state == CC_HEAT ||
			next_cc_state == CC_POSTCIRC; // [R8]
		next_service = next_cc_state == CC_SOFT ||
			(next_cc_state == CC_HARD && next_flash); // [R10] [R12]
		next_alarm = next_cc_state == CC_SOFT ||
			next_cc_state == CC_HARD; // [R10]
		next_vent = vent_en && (next_cc_state == CC_PRECIRC ||
			next_cc_state == CC_HEAT); // [R8] [R10]
		next_iso = iso_en && (next_cc_state == CC_PRECIRC ||
			next_cc_state == CC_HEAT); // [R8] [R10]
		next_pump = post_cont || next_cc_state == CC_PRECIRC ||
			next_cc_state == CC_HEAT ||
			(next_cc_state != CC_IDLE && next_sec < post_time); // [R10]
		st_shutdown = in_fault; // [R10]
		st_clear = exit_fault; // [R22]
		for (int i = 0; i < STAGES; i++) begin
			st_cold[i] = cc_state == CC_PRECIRC && stage_active[i] &&
				!cold_done[i]; // [R8]
			st_call[i] = cc_state == CC_HEAT && stage_active[i] &&
				i < int'(demand) &&
				(i == 0 || st_heating[i-1] || st_call[i-1] &&
				!st_heating[i-1] && 1'b0); // [R9]
		end
	end
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			cc_state <= CC_IDLE;
			sec <= 12'd0;
			fault_code <= FLT_NONE;
			cold_done <= 4'h0;
			flash <= 1'b0;
			sel_prev <= 1'b0;
			fault_log_strobe <= 1'b0;
			fault_log_code <= FLT_NONE;
			pump_on <= 1'b0;
			vent_output <= 1'b0;
			isolation_valve_output <= 1'b0;
			alarm_output <= 1'b0;
			led_standby <= 1'b0;
			led_running <= 1'b0;
			led_service <= 1'b0;
		end else begin
			cc_state <= next_cc_state;
			sec <= next_sec;
			fault_code <= next_fault_code;
			cold_done <= next_cold_done;
			flash <= next_flash;
			sel_prev <= s_sel;
			fault_log_strobe <= exit_fault;
			fault_log_code <= next_log_code;
			pump_on <= next_pump;
			vent_output <= next_vent;
			isolation_valve_output <= next_iso;
			alarm_output <= next_alarm;
			led_standby <= next_standby;
			led_running <= next_running;
			led_service <= next_service;
		end
	end

	// Read-back words
	assign status_word = {st_code, 8'h00, fault_code, 1'b0, cc_state};
	assign stage_err_word = {24'h000000, st_err_code};
endmodule

/* File: verification/bbs_partner.sv */
`timescale 1ns/1ps
module bbs_partner #(
	parameter int unsigned TICK_CYCLES = 10,
	parameter int STAGES = 4
) (
	// Clock and test controls
	input wire logic core_clk,
	input wire logic slow,
	input wire logic no_flame,
	// Device outputs
	input wire logic pump_on,
	input wire logic vent_output,
	input wire logic isolation_valve_output,
	input wire logic [STAGES-1:0] igniter_on,
	input wire logic [STAGES-1:0] gas_valve_on,
	// Sensed answers
	output logic water_flow,
	output logic vent_feedback,
	output logic isolation_valve_feedback,
	output logic [STAGES-1:0] igniter_current_ok,
	output logic [STAGES-1:0] flame_sensed,
	output logic [STAGES-1:0] gas_relay_feedback
);
	int ign_t[STAGES];
	int gas_t[STAGES];
	assign water_flow = pump_on;
	assign vent_feedback = vent_output;
	assign isolation_valve_feedback = isolation_valve_output;
	always_ff @(posedge core_clk) begin
		for (int i = 0; i < STAGES; i++) begin
			ign_t[i] <= igniter_on[i] ? ign_t[i] + 1 : 0;
			gas_t[i] <= gas_valve_on[i] ? gas_t[i] + 1 : 0;
		end
	end
	// Igniter warms up before it draws full current
	always_comb begin
		for (int i = 0; i < STAGES; i++) begin
			igniter_current_ok[i] = igniter_on[i] &&
				ign_t[i] >= 17 * TICK_CYCLES;
			gas_relay_feedback[i] = gas_valve_on[i];
			flame_sensed[i] = gas_valve_on[i] && !no_flame &&
				gas_t[i] >= (slow ? 3 * TICK_CYCLES : 1);
		end
	end
endmodule

/* File: verification/bbs_sequencer_assertions.sv */
`timescale 1ns/1ps
module bbs_sequencer_assertions #(
	parameter int unsigned TICK_CYCLES = 10,
	parameter int STAGES = 4
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Watched ports
	input wire logic led_standby,
	input wire logic led_running,
	input wire logic alarm_output,
	input wire logic vent_output,
	input wire logic isolation_valve_output,
	input wire logic fault_log_strobe,
	input wire logic [STAGES-1:0] flame_sensed,
	input wire logic [STAGES-1:0] igniter_on,
	input wire logic [STAGES-1:0] gas_valve_on
);
	import bbs_pkg::*;
	localparam int IGN_LOW = (int'(IGN_MIN_S) - 1) * int'(TICK_CYCLES);
	int ign_cnt;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// Igniter heat-up time before the gas opens
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset)
			ign_cnt <= 0;
		else
			ign_cnt <= (igniter_on[0] && !gas_valve_on[0]) ? ign_cnt + 1 : 0;
	end
	a_idle_quiet: assert property (led_standby |->
		!vent_output && !isolation_valve_output && !alarm_output)
		else $error("output on in idle");
	a_led_excl: assert property (!(led_standby && led_running))
		else $error("standby and running both lit");
	a_fault_quiet: assert property (alarm_output |->
		!led_running && !vent_output && !isolation_valve_output)
		else $error("fault outputs wrong");
	a_fault_gas_off: assert property ($rose(alarm_output) |->
		##[0:6] gas_valve_on == '0)
		else $error("gas open in fault");
	a_log_pulse: assert property (fault_log_strobe |=> !fault_log_strobe)
		else $error("log strobe too long");
	a_log_exit: assert property (fault_log_strobe |->
		##[0:2] !alarm_output)
		else $error("fault not left on log");
	a_gas_after_ign: assert property ($rose(gas_valve_on[0]) |->
		igniter_on[0] && ign_cnt >= IGN_LOW)
		else $error("gas opened before igniter heat-up");
	a_flame_ign_off: assert property (
		$fell(igniter_on[0]) && gas_valve_on[0] |-> $past(flame_sensed[0], 2))
		else $error("igniter off without flame");
endmodule
bind bbs_sequencer bbs_sequencer_assertions #(
	.TICK_CYCLES(TICK_CYCLES), .STAGES(STAGES)) chk_i (.*);

/* File: verification/bbs_sequencer_test.sv */
`timescale 1ns/1ps
module bbs_sequencer_test;
	import bbs_pkg::*;
	localparam int unsigned TK = 10;
	logic core_clk, reset, slow, no_flame;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb, fault_log_code, blower_on, igniter_on;
	logic [3:0] gas_valve_on, igniter_current_ok, flame_sensed;
	logic [3:0] gas_relay_feedback;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, overtemp_cutoff_switch;
	logic low_water_cutoff, flue_blocked, gas_pressure_low;
	logic outlet_high_limit, gas_pressure_high, isolation_valve_feedback;
	logic vent_feedback, water_flow, thermostat_closed, comm_lost;
	logic outlet_below_reset, user_select_key, error_screen_shown;
	logic pump_on, vent_output, isolation_valve_output, alarm_output;
	logic led_standby, led_running, led_service, fault_log_strobe;
	int failures = 0, checked = 0;
	bbs_sequencer #(.TICK_CYCLES(TK)) uut (.*);
	bbs_partner #(.TICK_CYCLES(TK)) model (.*);
	task results;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task chk(input logic [31:0] s, e);
		checked++;
		if (s !== e) begin
			failures++;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task to;
		failures++;
		results();
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
		logic ta, tw, tb;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= s;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		tb = 1'h0;
		for (int n = 0; n < 50 && !tb; n++) begin
			@(negedge core_clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid && s_axi_bready;
			r = s_axi_bresp;
			@(posedge core_clk);
			if (ta) s_axi_awvalid <= 1'h0;
			if (tw) s_axi_wvalid <= 1'h0;
			if (tb) s_axi_bready <= 1'h0;
		end
		if (!tb) to();
	endtask
	task rd(input logic [7:0] a);
		logic ta, tr;
		@(posedge core_clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		tr = 1'h0;
		for (int n = 0; n < 50 && !tr; n++) begin
			@(negedge core_clk);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid && s_axi_rready;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge core_clk);
			if (ta) s_axi_arvalid <= 1'h0;
			if (tr) s_axi_rready <= 1'h0;
		end
		if (!tr) to();
	endtask
	task poll(input logic [31:0] m, v);
		int n;
		for (n = 0; n < 1500; n++) begin
			rd(STATUS_OFF);
			if ((d & m) === v) break;
		end
		chk(d & m, v);
		if (n == 1500) results();
	endtask
	task enter(input logic [31:0] s);
		poll(32'h7, s);
		chk({alarm_output, led_running, led_service | s[0]}, 3'h5);
	endtask
	task leave(input logic [3:0] c);
		poll(32'h7, 32'h0);
		rd(LOG_OFF);
		chk(d, c);
		chk({fault_log_code, led_standby}, {c, 1'h1});
	endtask
	initial begin
		core_clk = 1'h0;
		forever #2.5 core_clk = ~core_clk;
	end
	initial begin
		reset = 1'h1;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, overtemp_cutoff_switch} = '0;
		{low_water_cutoff, flue_blocked, gas_pressure_low} = '0;
		{outlet_high_limit, gas_pressure_high, thermostat_closed} = '0;
		{comm_lost, outlet_below_reset, user_select_key} = '0;
		{error_screen_shown, slow, no_flame} = '0;
		repeat (6) @(posedge core_clk);
		reset <= 1'h0;
		wr(8'h10, 32'hFFFF_FFFF, 4'hF);
		chk(r, RESP_DECERR);
		rd(CTRL_OFF);
		chk(d, CTRL_RESET);
		chk({led_standby, pump_on}, 2'h2);
		$display("test idle done");
		wr(CTRL_OFF, 32'h0001_0000, 4'h4);
		rd(CTRL_OFF);
		chk(d, CTRL_RESET | 32'h0001_0000);
		slow <= 1'h1;
		thermostat_closed <= 1'h1;
		poll(32'h7, 32'h2);
		chk({led_running, vent_output, isolation_valve_output}, 3'h7);
		poll(32'hF_0000, 32'h5_0000);
		chk({gas_valve_on[0], igniter_on[0]}, 2'h2);
		thermostat_closed <= 1'h0;
		poll(32'hF_0000, 32'h7_0000);
		chk({gas_valve_on[0], blower_on[0]}, 2'h1);
		poll(32'hF_0000, 32'h0);
		chk(blower_on[0], 1'h0);
		$display("test heat done");
		{slow, no_flame, thermostat_closed} <= 3'h3;
		enter(32'h5);
		chk(d[19:16], 4'h8);
		rd(STAGE_ERR_OFF);
		chk(d[1:0], SERR_IGNITION);
		{no_flame, thermostat_closed, error_screen_shown} <= 3'h1;
		user_select_key <= 1'h1;
		repeat (4) @(posedge core_clk);
		user_select_key <= 1'h0;
		leave(FLT_STAGE);
		$display("test hard done");
		outlet_high_limit <= 1'h1;
		enter(32'h4);
		{outlet_high_limit, outlet_below_reset} <= 2'h1;
		leave(FLT_HIGH_LIMIT);
		comm_lost <= 1'h1;
		enter(32'h4);
		comm_lost <= 1'h0;
		leave(FLT_COMM);
		$display("test soft done");
		results();
	end
endmodule
